/* File: bench/awc_checker.sv */
`timescale 1ns/1ps
`include "awc_map.svh"
module awc_checker
  import awc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`AWC_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pready,
  input wire logic [31:0]            prdata,
  input wire logic                   pslverr,
  input wire awc_sample_s            core_sample,
  input wire awc_ctrl_s              core_cfg,
  input wire logic                   irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic acc;
  logic ctl_wr;
  logic rd;
  assign acc = psel && penable;
  assign ctl_wr = acc && pwrite && paddr == `AWC_OFF_CTRL;
  assign rd = acc && !pwrite;
  ////////////////////////////////////////
  pos_src_rst_a: assert property ($past(rst) |-> core_cfg.buf_pos_src == AWC_SRC_VCM)
    else $error("positive source not at reset value");
  neg_src_rst_a: assert property ($past(rst) |-> core_cfg.buf_neg_src == AWC_SRC_VCM)
    else $error("negative source not at reset value");
  cfg_write_a: assert property (ctl_wr && pstrb == 4'hf |=>
    core_cfg == ($past(pwdata) & `AWC_CTRL_WMASK)) else $error("control write lost");
  cfg_hold_a: assert property (!ctl_wr |=> $stable(core_cfg))
    else $error("control changed without a write");
  irq_master_a: assert property (irq |-> core_cfg.int_master)
    else $error("interrupt without master enable");
  irq_source_a: assert property (irq |-> core_cfg.rdy_ie || core_cfg.win_ie || core_cfg.ovf_ie)
    else $error("interrupt without an enabled source");
  status_zero_a: assert property (rd && paddr == `AWC_OFF_STATUS |-> prdata[31:3] == 0)
    else $error("status reserved bits set");
  result_upper_a: assert property (rd && paddr == `AWC_OFF_RESULT |-> prdata[31:16] == 0)
    else $error("result upper half set");
  unmapped_err_a: assert property (acc && paddr == 12'h000 |-> pslverr && pready)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (acc && paddr == `AWC_OFF_STATUS |-> !pslverr)
    else $error("mapped access refused");
  irq_seen_c: cover property ($rose(irq));
  err_seen_c: cover property (acc && pslverr);
  pop_seen_c: cover property (rd && paddr == `AWC_OFF_RESULT && prdata != 0);
endmodule

bind awc_top awc_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_awc_checker (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .core_sample(core_sample), .core_cfg(core_cfg), .irq(irq));

/* File: bench/awc_core_model.sv */
`timescale 1ns/1ps
module awc_core_model
  import awc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        send_en,
  input  wire logic [15:0] send_val,
  output awc_sample_s      core_sample
);
  // data toggles between results so a stale word never looks fresh
  always_ff @(posedge clk) begin
    if (rst) begin
      core_sample <= '{valid: 1'b0, data: 16'h5a5a};
    end else if (send_en) begin
      core_sample <= '{valid: 1'b1, data: send_val};
    end else begin
      core_sample <= '{valid: 1'b0, data: ~core_sample.data};
    end
  end
endmodule

/* File: bench/tb_awc_top.sv */
`timescale 1ns/1ps
`include "awc_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module tb_awc_top;
  import awc_pkg::*;
  localparam int DEPTH = 2;
  localparam logic [11:0] a_ctl = `AWC_OFF_CTRL, a_thr = `AWC_OFF_THRESH;
  localparam logic [11:0] a_sts = `AWC_OFF_STATUS, a_res = `AWC_OFF_RESULT;
  logic               clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, send_en = 0;
  logic [11:0]        paddr = 0;
  logic [31:0]        pwdata = 0, prdata, r;
  logic [3:0]         pstrb = 4'hf;
  logic               pready, pslverr, irq, last_err, w;
  logic [15:0]        send_val = 0;
  logic [15:0]        q [0:DEPTH];
  logic signed [15:0] v, hi, lo, a;
  logic [1:0]         rts [4] = '{2'd3, 2'd0, 2'd1, 2'd2};
  awc_sample_s        core_sample;
  awc_ctrl_s          core_cfg;
  int                 error_cnt = 0, n_compared = 0, seed = 32'h0258, n, sum;

  awc_top #(.FIFO_DEPTH(DEPTH)) i_awc_top (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .core_sample(core_sample),
    .core_cfg(core_cfg), .irq(irq));
  awc_core_model i_awc_core_model (.clk(clk), .rst(rst), .send_en(send_en),
    .send_val(send_val), .core_sample(core_sample));

  initial begin
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // an idle cycle after each transfer keeps psel from being driven twice in one step
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 16) begin
        error_cnt++;
        give_verdict();
      end
      @(posedge clk);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    `CHK(r, e)
  endtask
  task automatic send(input logic [15:0] d);
    send_en <= 1'b1;
    send_val <= d;
    @(posedge clk);
  endtask
  task automatic idle();
    send_en <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [31:0] cfg(logic im, logic av, logic [1:0] rt, logic ch, logic on);
    awc_ctrl_s c;
    c = `AWC_CTRL_RESET;
    c.int_master = im;
    c.rdy_ie = im;
    c.averaging_on = av;
    c.averaging_ratio = awc_ratio_e'(rt);
    c.window_input_choice = ch;
    c.window_check_on = on;
    return c;
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(a_ctl, `AWC_CTRL_RESET);
    rdc(a_thr, 32'h7fff_8000);
    rdc(a_sts, 32'h0);
    rdc(`AWC_OFF_MASK, 32'h7);
    rdc(a_res, 32'h0);
    rdc(12'h000, 32'h0);
    `CHK(last_err, 1'b1)
    apb(1'b1, a_ctl, 32'hffff_ffff);
    rdc(a_ctl, `AWC_CTRL_WMASK);
    apb(1'b1, a_sts, 32'hffff_ffff);
    rdc(a_sts, 32'h0);
    pstrb <= 4'h3;
    apb(1'b1, a_thr, 32'hffff_1234);
    pstrb <= 4'hf;
    rdc(a_thr, 32'h7fff_1234);
    $display("reset and access test done");
    hi = 16'($random(seed) & 32'h3fff);
    lo = -hi;
    apb(1'b1, a_thr, {hi, lo});
    apb(1'b1, a_ctl, cfg(0, 0, 0, 0, 1));
    for (int i = 0; i < 20; i++) begin
      case (i)
        0: v = hi;
        1: v = hi + 16'sd1;
        2: v = lo;
        3: v = lo - 16'sd1;
        default: v = 16'($random(seed));
      endcase
      send(v);
      idle();
      w = (v > hi) || (v < lo);
      rdc(a_sts, {30'h0, w, 1'b1});
      apb(1'b1, a_sts, 32'h0);
      rdc(a_res, {16'h0, v});
      rdc(a_sts, {30'h0, w, 1'b0});
      apb(1'b1, a_sts, 32'h2);
      rdc(a_sts, 32'h0);
    end
    apb(1'b1, a_ctl, cfg(0, 0, 0, 0, 0));
    send(16'h7fff);
    idle();
    rdc(a_sts, 32'h1);
    rdc(a_res, 32'h7fff);
    $display("raw window test done");
    for (int i = 0; i <= DEPTH; i++) begin
      q[i] = 16'($random(seed));
      send(q[i]);
    end
    idle();
    rdc(a_sts, 32'h5);
    for (int i = 0; i < DEPTH; i++) begin
      rdc(a_res, {16'h0, q[i]});
    end
    rdc(a_sts, 32'h4);
    apb(1'b1, a_sts, 32'h0);
    rdc(a_sts, 32'h4);
    apb(1'b1, a_sts, 32'h4);
    rdc(a_sts, 32'h0);
    $display("overflow test done");
    apb(1'b1, a_thr, 32'h1000_f000);
    foreach (rts[k]) begin
      n = 64 << (2 * (rts[k] == 2'd3 ? 0 : rts[k]));
      apb(1'b1, a_ctl, cfg(0, 1, rts[k], 1, 1));
      apb(1'b1, a_sts, 32'h6);
      sum = 0;
      for (int i = 0; i < n; i++) begin
        v = 16'($random(seed));
        sum += v;
        send(v);
      end
      idle();
      if (rts[k] == 2'd3) begin
        rdc(a_sts, 32'h0);
      end else begin
        a = 16'(sum >>> (6 + 2 * rts[k]));
        rdc(a_sts, {30'h0, (a > 16'sh1000) || (a < -16'sh1000), 1'b1});
        rdc(a_res, {16'h0, a});
      end
    end
    $display("averaging test done");
    apb(1'b1, a_ctl, cfg(1, 0, 0, 0, 0));
    send(16'h1234);
    idle();
    `CHK(irq, 1'b1)
    apb(1'b1, `AWC_OFF_MASK, 32'h6);
    `CHK(irq, 1'b0)
    apb(1'b1, `AWC_OFF_MASK, 32'h7);
    `CHK(irq, 1'b1)
    apb(1'b1, a_ctl, cfg(0, 0, 0, 0, 0));
    `CHK(irq, 1'b0)
    rdc(a_res, 32'h1234);
    $display("interrupt test done");
    give_verdict();
  end
endmodule

/* File: logic/awc_dummy_never.sv */
`timescale 1ns/1ps

/* File: logic/awc_fifo.sv */
`timescale 1ns/1ps
`include "awc_map.svh"

module awc_fifo
  import awc_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = `AWC_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         push_valid,
  input  wire logic [W-1:0] push_data,
  output logic              push_ready,
  input  wire logic         pop,
  output logic [W-1:0]      head,
  output logic              empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             count;
  } awc_fifo_s;

  awc_fifo_s st_q;
  awc_fifo_s st_d;
  logic      do_push;
  logic      do_pop;

  assign push_ready = (st_q.count != (AW+1)'(DEPTH));
  assign empty      = (st_q.count == '0);
  assign head       = st_q.mem[st_q.rd];
  assign do_push    = push_valid && push_ready;
  assign do_pop     = pop && !empty;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == (AW)'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    st_d = st_q;
    if (do_push) begin
      st_d.mem[st_q.wr] = push_data;
      st_d.wr           = bump(st_q.wr);
    end
    if (do_pop) begin
      st_d.rd = bump(st_q.rd);
    end
    st_d.count = st_q.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

/* File: logic/awc_map.svh */
// Behaviour
// R1: the positive buffer source field (bits 11:10) picks unused, common-mode, channel or ground, reset 01b.
// R2: the negative buffer source field (bits 9:8) uses the same coding and also resets to 01b.
// R3: bit 5 feeds the window check with the raw result when 0 and the averaged result when 1.
// R4: bit 4 turns the window check on; while it is 0 no window event is produced.
// R5: bit 0 turns averaging on and bits 2:1 set the ratio 64, 256 or 1024, with 11b reserved.
// R6: a compared result above the upper limit (threshold bits 31:16, reset 7fffh) raises a window event.
// R7: a compared result below the lower limit (threshold bits 15:0, reset 8000h) raises a window event.
// R8: status bit 2 holds the overflow event and is cleared by writing 1, a 0 leaves it alone.
// R9: status bit 1 holds the window event and is cleared by writing 1, a 0 leaves it alone.
// R10: status bit 0 shows a waiting result, is read-only and drops once the result is read out.
// R11: reading the result register pops one entry, shown signed in bits 15:0 with zero above.
// R12: the waiting flag is set as soon as a new result sits in the output buffer.
// R13: a result arriving while the output buffer is full sets the overflow flag.
// R14: the interrupt is high only with the master enable set and an enabled flag active.
// R15: reserved bits of status and result read as zero and ignore writes.
`ifndef AWC_MAP_SVH
`define AWC_MAP_SVH

`define AWC_ADDR_W      12
`define AWC_OFF_CTRL    12'h004
`define AWC_OFF_THRESH  12'h008
`define AWC_OFF_STATUS  12'h00c
`define AWC_OFF_RESULT  12'h010
`define AWC_OFF_MASK    12'h014

`define AWC_CTRL_RESET  32'h0001_a500
`define AWC_CTRL_WMASK  32'hffbb_fff7
`define AWC_UPPER_RESET 16'h7fff
`define AWC_LOWER_RESET 16'h8000
`define AWC_MASK_RESET  3'h7

`define AWC_BIT_OVF     2
`define AWC_BIT_WIN     1
`define AWC_BIT_RDY     0

`define AWC_ACC_W       26
`define AWC_CNT_W       11
`define AWC_N64         11'h03f
`define AWC_N256        11'h0ff
`define AWC_N1024       11'h3ff
`define AWC_SH64        6
`define AWC_SH256       8
`define AWC_SH1024      10

`define AWC_FIFO_DEPTH  4

`endif

/* File: logic/awc_pkg.sv */
`include "awc_map.svh"

package awc_pkg;

  typedef enum logic [1:0] {
    AWC_SRC_UNUSED = 2'b00,
    AWC_SRC_VCM    = 2'b01,
    AWC_SRC_CHAN   = 2'b10,
    AWC_SRC_GND    = 2'b11
  } awc_buf_src_e;

  typedef enum logic [1:0] {
    AWC_RATIO_64   = 2'b00,
    AWC_RATIO_256  = 2'b01,
    AWC_RATIO_1024 = 2'b10,
    AWC_RATIO_RSVD = 2'b11
  } awc_ratio_e;

  // laid out exactly as the control word, msb first
  typedef struct packed {
    logic         int_master;
    logic         rdy_ie;
    logic         win_ie;
    logic         ovf_ie;
    logic         tif_en;
    logic [2:0]   tif_sel;
    logic         buf_pd;
    logic         rsvd22;
    logic [1:0]   vref_sel;
    logic         buf_bypass;
    logic         rsvd18;
    logic [1:0]   pga_gain;
    logic [1:0]   drv_bias;
    logic [1:0]   pga_bias;
    awc_buf_src_e buf_pos_src;
    awc_buf_src_e buf_neg_src;
    logic [1:0]   res_sel;
    logic         window_input_choice;
    logic         window_check_on;
    logic         rsvd3;
    awc_ratio_e   averaging_ratio;
    logic         averaging_on;
  } awc_ctrl_s;

  typedef struct packed {
    logic overflow_flag;
    logic window_hit_flag;
    logic result_waiting_flag;
  } awc_flags_s;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] data;
  } awc_sample_s;

  typedef struct packed {
    awc_ctrl_s                       ctrl;
    logic signed [15:0]              upper_limit;
    logic signed [15:0]              lower_limit;
    awc_flags_s                      mask;
    logic                            overflow_flag;
    logic                            window_hit_flag;
    logic signed [`AWC_ACC_W-1:0]    acc;
    logic [`AWC_CNT_W-1:0]           cnt;
    logic [31:0]                     prdata;
    logic                            pslverr;
  } awc_state_s;

endpackage

/* File: logic/awc_top.sv */
`timescale 1ns/1ps
`include "awc_map.svh"

module awc_top
  import awc_pkg::*;
#(
  parameter int FIFO_DEPTH = `AWC_FIFO_DEPTH
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`AWC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // converter core
  input  wire awc_sample_s            core_sample,
  output awc_ctrl_s                   core_cfg,
  // interrupt
  output logic                        irq
);

  //////////////////////////////////////////////////////////////////////////////
  // state

  awc_state_s         st_q;
  awc_state_s         st_d;

  logic               setup;
  logic               access;
  logic               wr_ctrl;
  logic               wr_thresh;
  logic               wr_status;
  logic               wr_mask;
  logic               rd_result;
  logic               mapped;
  logic [31:0]        wmask;
  logic [31:0]        rd_word;

  logic               fifo_ready;
  logic               fifo_empty;
  logic [15:0]        fifo_head;
  logic               fifo_push;
  logic [15:0]        fifo_data;

  logic [`AWC_CNT_W-1:0] ratio_last;
  int unsigned        ratio_shift;
  logic               ratio_ok;
  logic signed [`AWC_ACC_W-1:0] acc_sum;
  logic               dec_valid;
  logic signed [15:0] dec_data;
  logic               cmp_valid;
  logic signed [15:0] cmp_data;
  logic               win_event;
  logic               ovf_event;
  awc_flags_s         flags;

  //////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign setup  = psel && !penable;
  assign access = psel && penable;
  // zero wait states: the answer was prepared in the setup cycle
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `AWC_OFF_CTRL, `AWC_OFF_THRESH, `AWC_OFF_STATUS,
      `AWC_OFF_RESULT, `AWC_OFF_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{pstrb[b]}};
    end
  end

  assign wr_ctrl   = access && pwrite && (paddr == `AWC_OFF_CTRL);
  assign wr_thresh = access && pwrite && (paddr == `AWC_OFF_THRESH);
  assign wr_status = access && pwrite && (paddr == `AWC_OFF_STATUS);
  assign wr_mask   = access && pwrite && (paddr == `AWC_OFF_MASK);
  assign rd_result = access && !pwrite && (paddr == `AWC_OFF_RESULT);   // R11

  // level flag: a push in the same cycle as the last pop keeps it set
  assign flags.result_waiting_flag = !fifo_empty;                      // R10 R12
  assign flags.window_hit_flag     = st_q.window_hit_flag;
  assign flags.overflow_flag       = st_q.overflow_flag;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (paddr)
      `AWC_OFF_CTRL:   rd_word = st_q.ctrl;
      `AWC_OFF_THRESH: rd_word = {st_q.upper_limit, st_q.lower_limit};
      `AWC_OFF_STATUS: rd_word = {29'h0000_0000, flags};                 // R15
      `AWC_OFF_RESULT: rd_word = fifo_empty ? 32'h0000_0000
                                            : {16'h0000, fifo_head};     // R11 R15
      `AWC_OFF_MASK:   rd_word = {29'h0000_0000, st_q.mask};
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // averaging filter

  always_comb begin
    ratio_last  = `AWC_N64;
    ratio_shift = `AWC_SH64;
    ratio_ok    = 1'b1;
    unique case (st_q.ctrl.averaging_ratio)                               // R5
      AWC_RATIO_64: begin
        ratio_last  = `AWC_N64;
        ratio_shift = `AWC_SH64;
      end
      AWC_RATIO_256: begin
        ratio_last  = `AWC_N256;
        ratio_shift = `AWC_SH256;
      end
      AWC_RATIO_1024: begin
        ratio_last  = `AWC_N1024;
        ratio_shift = `AWC_SH1024;
      end
      AWC_RATIO_RSVD: begin
        ratio_ok = 1'b0;
      end
    endcase
  end

  assign acc_sum   = st_q.acc + `AWC_ACC_W'(core_sample.data);
  // a ratio lowered mid-run must still close the block, hence >=
  assign dec_valid = st_q.ctrl.averaging_on && ratio_ok && core_sample.valid
                     && (st_q.cnt >= ratio_last);                          // R5
  assign dec_data  = 16'(acc_sum >>> ratio_shift);

  //////////////////////////////////////////////////////////////////////////////
  // window check and output buffer source

  assign cmp_valid = st_q.ctrl.window_input_choice ? dec_valid : core_sample.valid; // R3
  assign cmp_data  = st_q.ctrl.window_input_choice ? dec_data : core_sample.data;   // R3
  assign win_event = st_q.ctrl.window_check_on && cmp_valid                         // R4
                     && ((cmp_data > st_q.upper_limit)                              // R6
                     ||  (cmp_data < st_q.lower_limit));                            // R7

  assign fifo_push = st_q.ctrl.averaging_on ? dec_valid : core_sample.valid;
  assign fifo_data = st_q.ctrl.averaging_on ? dec_data : core_sample.data;
  // the sample is dropped, the stored results are kept
  assign ovf_event = fifo_push && !fifo_ready;                            // R13

  awc_fifo #(
    .W     (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk        (clk),
    .rst        (rst),
    .push_valid (fifo_push),
    .push_data  (fifo_data),
    .push_ready (fifo_ready),
    .pop        (rd_result),                                              // R10 R11
    .head       (fifo_head),
    .empty      (fifo_empty)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_d = st_q;

    if (wr_ctrl) begin
      st_d.ctrl = awc_ctrl_s'((st_q.ctrl & ~(wmask & `AWC_CTRL_WMASK))
                            | (pwdata & wmask & `AWC_CTRL_WMASK));        // R1 R2
    end
    if (wr_thresh) begin
      st_d.upper_limit = (st_q.upper_limit & ~wmask[31:16]) | (pwdata[31:16] & wmask[31:16]);
      st_d.lower_limit = (st_q.lower_limit & ~wmask[15:0]) | (pwdata[15:0] & wmask[15:0]);
    end
    if (wr_mask && pstrb[0]) begin
      st_d.mask = pwdata[2:0];
    end

    // write one clears, a new event in the same cycle wins
    st_d.overflow_flag = (st_q.overflow_flag
                         & ~(wr_status && pstrb[0] && pwdata[`AWC_BIT_OVF]))
                         | ovf_event;                                     // R8
    st_d.window_hit_flag = (st_q.window_hit_flag
                           & ~(wr_status && pstrb[0] && pwdata[`AWC_BIT_WIN]))
                           | win_event;                                   // R9

    if (!st_q.ctrl.averaging_on || !ratio_ok) begin
      st_d.acc = '0;
      st_d.cnt = '0;
    end else if (core_sample.valid) begin
      if (dec_valid) begin
        st_d.acc = '0;
        st_d.cnt = '0;
      end else begin
        st_d.acc = acc_sum;
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end

    if (setup) begin
      st_d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      st_d.pslverr = !mapped;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q             <= '0;
      st_q.ctrl        <= awc_ctrl_s'(`AWC_CTRL_RESET);                   // R1 R2
      st_q.upper_limit <= `AWC_UPPER_RESET;                               // R6
      st_q.lower_limit <= `AWC_LOWER_RESET;                               // R7
      st_q.mask        <= `AWC_MASK_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata   = st_q.prdata;
  assign pslverr  = st_q.pslverr && access;
  assign core_cfg = st_q.ctrl;

  assign irq = st_q.ctrl.int_master                                       // R14
               && |(flags & st_q.mask
                    & {st_q.ctrl.ovf_ie, st_q.ctrl.win_ie, st_q.ctrl.rdy_ie});

endmodule
